// ### lcg_defs.vh
// register map, field positions and reset values of the logic cell input stage
`ifndef LCG_DEFS_VH
`define LCG_DEFS_VH

// word offsets on the system bus (byte addresses)
`define LCG_ADDR_CTRL 8'h00
`define LCG_ADDR_POL 8'h04
`define LCG_ADDR_SEL 8'h08
`define LCG_ADDR_GLO 8'h0C
`define LCG_ADDR_GHI 8'h10
`define LCG_ADDR_STAT 8'h14

// control register fields
`define LCG_CTRL_EN_BIT 15
`define LCG_CTRL_MASK 16'h8000

// polarity register: four bits, rest read zero
`define LCG_POL_W 4
`define LCG_POL_MASK 16'h000F

// source select fields, 3 bits each
`define LCG_SEL_MUX1_LSB 0
`define LCG_SEL_MUX2_LSB 4
`define LCG_SEL_MUX3_LSB 8
`define LCG_SEL_MUX4_LSB 12
`define LCG_SEL_MASK 16'h7777

// gate enables: one byte per gate, low byte gate 1 (or 3)
`define LCG_GATE_BYTE_W 8

// reset values
`define LCG_RST_CTRL 16'h0000
`define LCG_RST_POL 16'h0000
`define LCG_RST_SEL 16'h0000
`define LCG_RST_GATE 16'h0000

`endif

// ### lcg_gate.v
// one input gate: or of enabled true and negated sources, then polarity
`timescale 1ns/1ns
`default_nettype none

module lcg_gate (
  input wire [3:0] data_i,
  input wire [7:0] enable_i,
  input wire invert_i,
  output wire gate_o
);

  wire [7:0] terms;

  // byte layout per source n: bit 2n+1 true, bit 2n negated
  genvar n;
  generate
    for (n = 0; n < 4; n = n + 1) begin : g_src
      assign terms[2*n+1] = enable_i[2*n+1] & data_i[n];
      assign terms[2*n] = enable_i[2*n] & ~data_i[n];
    end
  endgenerate

  // no enables gives zero before polarity
  assign gate_o = (|terms) ^ invert_i;

endmodule // lcg_gate

`default_nettype wire

// ### lcg_cell.v
// input stage of a configurable logic cell with a wishbone register slave
//
// Implementation choices: the address map and the Wishbone interface to the registers.
`timescale 1ns/1ns
`default_nettype none
`include "lcg_defs.vh"

// Summary of operation
// - each of four polarity bits inverts its gate result when set.
// - polarity bits 15 to 4 store nothing and read zero.
// - source select holds four 3-bit selectors, gaps read zero.
// - mux 1 routes pin a, cycle clock, osc, rc, ref clock, 0, t2, t3.
// - mux 2 routes pin b, cell, cmp1, tx, adc, dma0, cmp ev 1, 2.
// - mux 3 routes pin a, own cell, cmp2, sdo, rx, dma1, ev 2, 3.
// - mux 4 routes pin b, cell, cmp3, sdi, touch trig, 0, ev 1, 3.
// - code 001 picks the paired cell on mux 2 and 4, own on mux 3.
// - serial sources follow the cell number; cell 4 lacks sdi and sdo.
// - low enable register holds gate 2 in the high byte, gate 1 low.
// - a set true enable feeds the plain source into its gate.
// - a set negated enable feeds the inverted source into its gate.
// - each gate ors all enabled terms, up to eight.
// - high enable register holds gate 4 high byte, gate 3 low byte.
// - with the cell disabled the gate outputs are driven zero.
module lcg_cell #(
  parameter CELL_NUM = 1
) (
  input wire clk_i,
  input wire rst_i,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output reg [31:0] wb_dat_o,
  output reg wb_ack_o,
  output reg wb_err_o,
  input wire cell_input_pin_a_i,
  input wire cell_input_pin_b_i,
  input wire cycle_clock_i,
  input wire secondary_osc_clock_i,
  input wire low_power_rc_clock_i,
  input wire reference_clock_out_i,
  input wire timer2_match_i,
  input wire timer3_match_i,
  input wire own_cell_out_i,
  input wire pair_cell_out_i,
  input wire comparator1_out_i,
  input wire comparator2_out_i,
  input wire comparator3_out_i,
  input wire serial_tx_i,
  input wire serial_rx_i,
  input wire serial_periph_data_in_i,
  input wire serial_periph_data_out_i,
  input wire adc_done_irq_i,
  input wire dma0_irq_i,
  input wire dma1_irq_i,
  input wire touch_adc_trigger_i,
  input wire compare1_event_flag_i,
  input wire compare2_event_flag_i,
  input wire compare3_event_flag_i,
  output reg [3:0] gate_o,
  output reg cell_enable_o
);

  // serial peripheral data exists on cells 1 to 3 only
  localparam HAS_SPI = (CELL_NUM != 4) ? 1'b1 : 1'b0;

  // ==========================================================
  // registers
  reg [15:0] ctrl_q;
  reg [15:0] pol_q;
  reg [15:0] sel_q;
  reg [15:0] glo_q;
  reg [15:0] ghi_q;

  wire req;
  wire mapped;
  wire [1:0] wr_lo;
  reg [15:0] rd_d;

  assign req = wb_cyc_i & wb_stb_i & ~wb_ack_o & ~wb_err_o;
  assign mapped = (wb_adr_i == `LCG_ADDR_CTRL) ||
                  (wb_adr_i == `LCG_ADDR_POL) ||
                  (wb_adr_i == `LCG_ADDR_SEL) ||
                  (wb_adr_i == `LCG_ADDR_GLO) ||
                  (wb_adr_i == `LCG_ADDR_GHI) ||
                  (wb_adr_i == `LCG_ADDR_STAT);
  assign wr_lo = wb_sel_i[1:0];

  // byte-lane merge of a 16-bit register with write data
  function [15:0] merge;
    input [15:0] old;
    input [15:0] nw;
    input [1:0] lanes;
    input [15:0] mask;
    begin
      merge = old;
      if (lanes[0]) begin
        merge[7:0] = nw[7:0];
      end
      if (lanes[1]) begin
        merge[15:8] = nw[15:8];
      end
      merge = merge & mask;
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      ctrl_q <= `LCG_RST_CTRL;
      pol_q <= `LCG_RST_POL;
      sel_q <= `LCG_RST_SEL;
      glo_q <= `LCG_RST_GATE;
      ghi_q <= `LCG_RST_GATE;
    end else if (req && wb_we_i) begin
      case (wb_adr_i)
        `LCG_ADDR_CTRL: begin
          ctrl_q <= merge(ctrl_q, wb_dat_i[15:0], wr_lo, `LCG_CTRL_MASK);
        end
        `LCG_ADDR_POL: begin
          pol_q <= merge(pol_q, wb_dat_i[15:0], wr_lo, `LCG_POL_MASK);
        end
        `LCG_ADDR_SEL: begin
          sel_q <= merge(sel_q, wb_dat_i[15:0], wr_lo, `LCG_SEL_MASK);
        end
        `LCG_ADDR_GLO: begin
          glo_q <= merge(glo_q, wb_dat_i[15:0], wr_lo, 16'hFFFF);
        end
        `LCG_ADDR_GHI: begin
          ghi_q <= merge(ghi_q, wb_dat_i[15:0], wr_lo, 16'hFFFF);
        end
        default: begin
          ctrl_q <= ctrl_q;
        end
      endcase
    end
  end

  // ==========================================================
  // read mux
  always @* begin
    case (wb_adr_i)
      `LCG_ADDR_CTRL: rd_d = ctrl_q;
      `LCG_ADDR_POL: rd_d = pol_q;
      `LCG_ADDR_SEL: rd_d = sel_q;
      `LCG_ADDR_GLO: rd_d = glo_q;
      `LCG_ADDR_GHI: rd_d = ghi_q;
      `LCG_ADDR_STAT: rd_d = {12'h000, gate_o};
      default: rd_d = 16'h0000;
    endcase
  end

  // one wait state: ack or err one cycle after the request is seen
  always @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_err_o <= 1'b0;
      wb_dat_o <= 32'h0000_0000;
    end else begin
      wb_ack_o <= req & mapped;
      wb_err_o <= req & ~mapped;
      wb_dat_o <= (req && mapped && !wb_we_i) ? {16'h0000, rd_d} :
                  32'h0000_0000;
    end
  end

  // ==========================================================
  // data source multiplexers
  wire [2:0] s1 = sel_q[`LCG_SEL_MUX1_LSB +: 3];
  wire [2:0] s2 = sel_q[`LCG_SEL_MUX2_LSB +: 3];
  wire [2:0] s3 = sel_q[`LCG_SEL_MUX3_LSB +: 3];
  wire [2:0] s4 = sel_q[`LCG_SEL_MUX4_LSB +: 3];
  reg [3:0] data_d;

  always @* begin
    case (s1)
      3'h0: data_d[0] = cell_input_pin_a_i;
      3'h1: data_d[0] = cycle_clock_i;
      3'h2: data_d[0] = secondary_osc_clock_i;
      3'h3: data_d[0] = low_power_rc_clock_i;
      3'h4: data_d[0] = reference_clock_out_i;
      3'h6: data_d[0] = timer2_match_i;
      3'h7: data_d[0] = timer3_match_i;
      default: data_d[0] = 1'b0;
    endcase
    case (s2)
      3'h0: data_d[1] = cell_input_pin_b_i;
      3'h1: data_d[1] = pair_cell_out_i;
      3'h2: data_d[1] = comparator1_out_i;
      3'h3: data_d[1] = serial_tx_i;
      3'h4: data_d[1] = adc_done_irq_i;
      3'h5: data_d[1] = dma0_irq_i;
      3'h6: data_d[1] = compare1_event_flag_i;
      default: data_d[1] = compare2_event_flag_i;
    endcase
    case (s3)
      3'h0: data_d[2] = cell_input_pin_a_i;
      3'h1: data_d[2] = own_cell_out_i;
      3'h2: data_d[2] = comparator2_out_i;
      3'h3: data_d[2] = serial_periph_data_out_i & HAS_SPI;
      3'h4: data_d[2] = serial_rx_i;
      3'h5: data_d[2] = dma1_irq_i;
      3'h6: data_d[2] = compare2_event_flag_i;
      default: data_d[2] = compare3_event_flag_i;
    endcase
    case (s4)
      3'h0: data_d[3] = cell_input_pin_b_i;
      3'h1: data_d[3] = pair_cell_out_i;
      3'h2: data_d[3] = comparator3_out_i;
      3'h3: data_d[3] = serial_periph_data_in_i & HAS_SPI;
      3'h4: data_d[3] = touch_adc_trigger_i;
      3'h6: data_d[3] = compare1_event_flag_i;
      3'h7: data_d[3] = compare3_event_flag_i;
      default: data_d[3] = 1'b0;
    endcase
  end

  // ==========================================================
  // input gates
  wire [31:0] gate_en = {ghi_q, glo_q};
  wire [3:0] gate_d;

  genvar g;
  generate
    for (g = 0; g < 4; g = g + 1) begin : g_gate
      lcg_gate u_gate (
        .data_i(data_d),
        .enable_i(gate_en[g*8 +: 8]),
        .invert_i(pol_q[g]),
        .gate_o(gate_d[g])
      );
    end
  endgenerate

  always @(posedge clk_i) begin
    if (rst_i) begin
      gate_o <= 4'h0;
      cell_enable_o <= 1'b0;
    end else begin
      cell_enable_o <= ctrl_q[`LCG_CTRL_EN_BIT];
      gate_o <= ctrl_q[`LCG_CTRL_EN_BIT] ? gate_d : 4'h0;
    end
  end

endmodule // lcg_cell

`default_nettype wire

// ### lcg_cell_asserts.sv
// bus and gate checker for the logic cell input stage
`timescale 1ns/1ns
`default_nettype none
module lcg_cell_asserts (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic wb_err_o,
  input wire logic [3:0] gate_o,
  input wire logic cell_enable_o
);
  // ==========
  // request decode
  wire req = wb_cyc_i && wb_stb_i && !wb_ack_o && !wb_err_o;
  wire rd = wb_ack_o && !wb_we_i;
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // ==========
  // properties
  property p_ack; req && wb_adr_i < 8'h18 && wb_adr_i[1:0] == 2'h0
    |=> wb_ack_o && !wb_err_o; endproperty
  a_ack: assert property (p_ack) else $error("mapped access not acked");
  property p_err; req && wb_adr_i > 8'h14 |=> wb_err_o && wb_dat_o == 0;
  endproperty
  a_err: assert property (p_err) else $error("unmapped access not refused");
  property p_one; wb_ack_o |=> !wb_ack_o; endproperty
  a_one: assert property (p_one) else $error("ack longer than a cycle");
  property p_pol; rd && wb_adr_i == 8'h04 |-> wb_dat_o[31:4] == 0; endproperty
  a_pol: assert property (p_pol) else $error("polarity gap bits set");
  property p_sel; rd && wb_adr_i == 8'h08 |-> (wb_dat_o & 32'hffff_8888) == 0;
  endproperty
  a_sel: assert property (p_sel) else $error("select gap bits set");
  property p_off; !cell_enable_o [*2] |-> gate_o == 4'h0; endproperty
  a_off: assert property (p_off) else $error("gates live while off");
  property p_sts; rd && wb_adr_i == 8'h14
    |-> wb_dat_o == {28'h000_0000, $past(gate_o)}; endproperty
  a_sts: assert property (p_sts) else $error("status differs from gates");
  property p_rst; $fell(rst_i) |-> !wb_ack_o && gate_o == 4'h0 && !cell_enable_o;
  endproperty
  a_rst: assert property (p_rst) else $error("outputs not cleared by reset");
endmodule // lcg_cell_asserts
bind lcg_cell lcg_cell_asserts chk_u (.*);
`default_nettype wire

// ### lcg_src_model.sv
// model of the pins and peripherals that feed the cell
`timescale 1ns/1ns
`default_nettype none
module lcg_src_model (
  input wire logic clk_i,
  input wire logic [23:0] pat_i,
  output logic [23:0] src_o
);
  // sources are synchronous levels, changing just after an edge
  always @(posedge clk_i) begin
    src_o <= pat_i;
  end
endmodule // lcg_src_model
`default_nettype wire

// ### lcg_cell_bench.sv
// self-checking bench for the logic cell input stage
`timescale 1ns/1ns
`default_nettype none
module lcg_cell_bench;
  logic clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hf;
  logic [31:0] wb_dat_i = 32'h0000_0000;
  logic [31:0] wb_dat_o;
  logic [31:0] q[$];
  logic wb_ack_o, wb_err_o, cell_enable_o;
  logic [3:0] gate_o;
  logic [23:0] pat = 24'h00_0000, src;
  int num_errors = 0, tests_run = 0;
  // source index per select code, 24 is a constant zero
  int tb[4][8] = '{'{0, 2, 3, 4, 5, 24, 6, 7}, '{1, 9, 10, 13, 17, 18, 21, 22},
    '{0, 8, 11, 16, 14, 19, 22, 23}, '{1, 9, 12, 15, 20, 24, 21, 23}};
  initial forever #10 clk_i = ~clk_i;
  lcg_src_model src_u (.clk_i(clk_i), .pat_i(pat), .src_o(src));
  lcg_cell dut_u (.*, .cell_input_pin_a_i(src[0]), .cell_input_pin_b_i(src[1]),
    .cycle_clock_i(src[2]), .secondary_osc_clock_i(src[3]),
    .low_power_rc_clock_i(src[4]), .reference_clock_out_i(src[5]),
    .timer2_match_i(src[6]), .timer3_match_i(src[7]),
    .own_cell_out_i(src[8]), .pair_cell_out_i(src[9]),
    .comparator1_out_i(src[10]), .comparator2_out_i(src[11]),
    .comparator3_out_i(src[12]), .serial_tx_i(src[13]), .serial_rx_i(src[14]),
    .serial_periph_data_in_i(src[15]), .serial_periph_data_out_i(src[16]),
    .adc_done_irq_i(src[17]), .dma0_irq_i(src[18]), .dma1_irq_i(src[19]),
    .touch_adc_trigger_i(src[20]), .compare1_event_flag_i(src[21]),
    .compare2_event_flag_i(src[22]), .compare3_event_flag_i(src[23]));
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic test_done;
    $display("mismatches %0d, comparisons %0d", num_errors, tests_run);
    if (num_errors == 0 && tests_run > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // one classic cycle; a read notes its expected data first
  task automatic wb(input logic we, input logic [7:0] a, input logic [15:0] d);
    int n;
    n = 0;
    if (!we) q.push_back({16'h0000, d});
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= we;
    wb_adr_i <= a;
    wb_dat_i <= {16'h0000, we ? d : 16'h0000};
    do begin
      @(posedge clk_i);
      n++;
    end while (!(wb_ack_o || wb_err_o) && n < 20);
    if (!(wb_ack_o || wb_err_o)) begin
      num_errors++;
      test_done;
    end
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if ((wb_ack_o || wb_err_o) && !wb_we_i && q.size() > 0) begin
      chk(wb_dat_o, q.pop_front());
    end
  end
  function automatic logic [3:0] gexp(input logic [15:0] s, lo, hi,
      input logic [3:0] p, input logic en);
    logic [3:0] d, g;
    logic [7:0] e;
    logic [24:0] v;
    v = {1'b0, pat};
    for (int i = 0; i < 4; i++) d[i] = v[tb[i][s[4*i+:3]]];
    for (int k = 0; k < 4; k++) begin
      e = k < 2 ? lo[8*k+:8] : hi[8*(k-2)+:8];
      g[k] = 1'b0;
      for (int i = 0; i < 4; i++) g[k] |= (e[2*i+1] & d[i]) | (e[2*i] & ~d[i]);
      g[k] ^= p[k];
    end
    return en ? g : 4'h0;
  endfunction
  initial begin
    logic [15:0] s, lo, hi;
    logic [3:0] p;
    logic en;
    void'($urandom(58465));
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    for (int a = 0; a < 7; a++) wb(1'b0, 8'(4 * a), 16'h0000);
    wb(1'b1, 8'h04, 16'hffff);
    wb(1'b0, 8'h04, 16'h000f);
    wb(1'b1, 8'h08, 16'hffff);
    wb(1'b0, 8'h08, 16'h7777);
    wb(1'b1, 8'h00, 16'hffff);
    wb(1'b1, 8'h18, 16'h0000);
    wb(1'b0, 8'h00, 16'h8000);
    for (int i = 0; i < 48; i++) begin
      s = i < 8 ? {4{1'b0, i[2:0]}} : 16'($urandom) & 16'h7777;
      lo = i % 5 == 0 ? 16'h0000 : 16'($urandom);
      hi = 16'($urandom);
      p = 4'($urandom);
      en = i < 8 || i % 7 != 0;
      wb(1'b1, 8'h00, {en, 15'h0000});
      wb(1'b1, 8'h04, {12'h000, p});
      wb(1'b1, 8'h08, s);
      wb(1'b1, 8'h0C, lo);
      wb(1'b1, 8'h10, hi);
      pat <= 24'($urandom);
      repeat (3) @(posedge clk_i);
      chk({31'h0000_0000, cell_enable_o}, {31'h0000_0000, en});
      wb(1'b0, 8'h14, {12'h000, gexp(s, lo, hi, p, en)});
    end
    test_done;
  end
endmodule // lcg_cell_bench
`default_nettype wire
